/* inc/qc_host_pkg.sv */
// constants shared by the host-side bus and count-pin controller
// ==========================================
// Overview of operation
// - act only with select low; C/D picks bank
// - reload value written as bytes 0,1,2
// - snapshot read back as bytes 0,1,2
// - direction input changes only while A high
package qc_host_pkg;

   // ==========================================
   // clock, bus and count-pin timing
   localparam int unsigned CLK_NS      = 20;
   localparam int unsigned T_CD_SU_NS  = 30;   // select/data setup before strobe
   localparam int unsigned T_WR_NS     = 60;   // write strobe width
   localparam int unsigned T_RD_NS     = 110;  // read strobe to data valid
   localparam int unsigned T_HOLD_NS   = 30;   // select/data hold after strobe
   localparam int unsigned T_GAP_NS    = 60;   // spacing between two accesses
   localparam int unsigned T_CNT_LO_NS = 18;   // count input low time
   localparam int unsigned T_CNT_HI_NS = 22;   // count input high time
   localparam int unsigned T_REV_NS    = 100;  // up/down reversal delay

   function automatic int unsigned min_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [3:0] SU_CYC   = 4'(min_cyc(T_CD_SU_NS));
   localparam logic [3:0] WR_CYC   = 4'(min_cyc(T_WR_NS));
   localparam logic [3:0] RD_CYC   = 4'(min_cyc(T_RD_NS) + 1);  // one spare for sampling
   localparam logic [3:0] HOLD_CYC = 4'(min_cyc(T_HOLD_NS));
   localparam logic [3:0] GAP_CYC  = 4'(min_cyc(T_GAP_NS));
   localparam logic [3:0] LO_CYC   = 4'(min_cyc(T_CNT_LO_NS));
   localparam logic [3:0] HI_CYC   = 4'(min_cyc(T_CNT_HI_NS));
   localparam logic [3:0] REV_CYC  = 4'(min_cyc(T_REV_NS));

   // ==========================================
   // user command codes
   localparam logic [1:0] OP_CTRL_WR   = 2'h0;  // one control byte
   localparam logic [1:0] OP_RELOAD_WR = 2'h1;  // three data writes
   localparam logic [1:0] OP_SNAP_RD   = 2'h2;  // three data reads
   localparam logic [1:0] OP_STATUS_RD = 2'h3;  // one control read

   // ==========================================
   // device control byte layout
   localparam int unsigned SEL_POS          = 6;
   localparam logic [1:0]  SEL_MASTER       = 2'h0;
   localparam logic [1:0]  SEL_INPUT_SETUP  = 2'h1;
   localparam logic [1:0]  SEL_OUTPUT_SETUP = 2'h2;
   localparam logic [1:0]  SEL_PHASE_DECODE = 2'h3;
   localparam logic [7:0]  MC_RST_PTR       = 8'h01;
   localparam logic [7:0]  MC_SNAPSHOT      = 8'h02;
   localparam logic [7:0]  MC_CLEAR_CNT     = 8'h04;
   localparam logic [7:0]  MC_LOAD_CNT      = 8'h08;
   localparam logic [7:0]  MC_CLR_MATCH     = 8'h10;
   localparam logic [7:0]  MC_MASTER_RST    = 8'h20;
   localparam logic [7:0]  STATUS_MASK      = 8'h1f;
   localparam logic [23:0] RELOAD_RST       = 24'hffffff;

endpackage

/* hw/qc_count_pins.sv */
// count-pin driver: A as count clock, B as direction
`timescale 1ns/1ps
module qc_count_pins
   import qc_host_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // step requests
   input  wire logic step_req,
   input  wire logic step_down,
   output logic      step_ready,
   // count pins
   output logic      pin_a,
   output logic      pin_b
);

   typedef enum logic [1:0] {P_IDLE, P_TURN, P_LOW, P_HIGH} pin_state_t;

   pin_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic       a_q, a_d, b_q, b_d, rdy_q, rdy_d, dn_q, dn_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      a_d     = a_q;
      b_d     = b_q;
      rdy_d   = rdy_q;
      dn_d    = dn_q;
      case (state_q)
         P_IDLE: begin
            if (step_req && rdy_q) begin
               rdy_d = 1'b0;
               dn_d  = step_down;
               if (step_down != b_q) begin
                  // a rests high, so direction may turn here
                  b_d     = step_down;
                  cnt_d   = REV_CYC;
                  state_d = P_TURN;
               end else begin
                  a_d     = 1'b0;
                  cnt_d   = LO_CYC;
                  state_d = P_LOW;
               end
            end
         end
         P_TURN: begin
            if (cnt_q <= 4'h1) begin
               a_d     = 1'b0;
               cnt_d   = LO_CYC;
               state_d = P_LOW;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         P_LOW: begin
            if (cnt_q <= 4'h1) begin
               a_d     = 1'b1;
               cnt_d   = HI_CYC;
               state_d = P_HIGH;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         P_HIGH: begin
            if (cnt_q <= 4'h1) begin
               rdy_d   = 1'b1;
               state_d = P_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: state_d = P_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= P_IDLE;
         cnt_q   <= 4'h0;
         a_q     <= 1'b1;
         b_q     <= 1'b0;
         rdy_q   <= 1'b1;
         dn_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         a_q     <= a_d;
         b_q     <= b_d;
         rdy_q   <= rdy_d;
         dn_q    <= dn_d;
      end
   end

   assign step_ready = rdy_q;
   assign pin_a      = a_q;
   assign pin_b      = b_q;

endmodule

/* hw/qc_host.sv */
// host controller for the 24-bit counter's byte bus and count pins
`timescale 1ns/1ps
module qc_host
   import qc_host_pkg::*;
#(
   parameter int unsigned BYTE_W = 8
)
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // user command port
   input  wire logic        CMD_VALID,
   input  wire logic [1:0]  CMD_OP,
   input  wire logic [23:0] CMD_DATA,
   output logic             CMD_READY,
   output logic             RSP_VALID,
   output logic [23:0]      RSP_DATA,
   // user step port
   input  wire logic        STEP_REQ,
   input  wire logic        STEP_DOWN,
   output logic             STEP_READY,
   // device bus
   output logic             CS_N,
   output logic             CD,
   output logic             RD_N,
   output logic             WR_N,
   input  wire logic [7:0]  DB_IN,
   output logic [7:0]       DB_OUT,
   output logic             DB_OE,
   // device count pins
   output logic             CNT_A,
   output logic             CNT_B
);

   generate
      if (BYTE_W != 8) begin : g_bad_width
         $error("qc_host serves an 8-bit device bus only");
      end
   endgenerate

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP} bus_state_t;

   // reload and snapshot take three bytes, control and status one
   function automatic logic [1:0] last_byte(input logic [1:0] op);
      return (op == OP_RELOAD_WR || op == OP_SNAP_RD) ? 2'h2 : 2'h0;
   endfunction

   function automatic logic is_read(input logic [1:0] op);
      return op == OP_SNAP_RD || op == OP_STATUS_RD;
   endfunction

   // ==========================================
   // bus sequencer
   bus_state_t  state_q, state_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [1:0]  byte_q, byte_d, op_q, op_d;
   logic [23:0] wdata_q, wdata_d, rdata_q, rdata_d, rsp_q, rsp_d;
   logic        cs_n_q, cs_n_d, cd_q, cd_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
   logic [7:0]  dout_q, dout_d;
   logic        oe_q, oe_d, ready_q, ready_d, rsp_v_q, rsp_v_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      byte_d  = byte_q;
      op_d    = op_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      rsp_d   = rsp_q;
      cs_n_d  = cs_n_q;
      cd_d    = cd_q;
      rd_n_d  = rd_n_q;
      wr_n_d  = wr_n_q;
      dout_d  = dout_q;
      oe_d    = oe_q;
      ready_d = ready_q;
      rsp_v_d = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (CMD_VALID && ready_q) begin
               ready_d = 1'b0;
               op_d    = CMD_OP;
               wdata_d = CMD_DATA;
               rdata_d = 24'h000000;
               byte_d  = 2'h0;
               state_d = S_SETUP;
               cnt_d   = SU_CYC;
               cs_n_d  = 1'b0;
               // control bank for control writes and status reads
               cd_d    = (CMD_OP == OP_CTRL_WR || CMD_OP == OP_STATUS_RD);
               dout_d  = CMD_DATA[7:0];
               oe_d    = !is_read(CMD_OP);
            end
         end
         S_SETUP: begin
            if (cnt_q <= 4'h1) begin
               state_d = S_STROBE;
               if (is_read(op_q)) begin
                  rd_n_d = 1'b0;
                  cnt_d  = RD_CYC;
               end else begin
                  wr_n_d = 1'b0;
                  cnt_d  = WR_CYC;
               end
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_STROBE: begin
            if (cnt_q <= 4'h1) begin
               if (is_read(op_q)) begin
                  // bytes arrive low first as the device pointer advances
                  rdata_d[8*byte_q +: 8] = (op_q == OP_STATUS_RD) ?
                                           (DB_IN & STATUS_MASK) : DB_IN;
               end
               rd_n_d  = 1'b1;
               wr_n_d  = 1'b1;
               cnt_d   = HOLD_CYC;
               state_d = S_HOLD;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_HOLD: begin
            if (cnt_q <= 4'h1) begin
               cs_n_d  = 1'b1;
               oe_d    = 1'b0;
               cnt_d   = GAP_CYC;
               state_d = S_GAP;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         S_GAP: begin
            if (cnt_q <= 4'h1) begin
               if (byte_q == last_byte(op_q)) begin
                  state_d = S_IDLE;
                  ready_d = 1'b1;
                  rsp_v_d = is_read(op_q);
                  rsp_d   = rdata_q;
               end else begin
                  // next byte of reload or snapshot, bytes 0 then 1 then 2
                  byte_d  = byte_q + 2'h1;
                  dout_d  = wdata_q[8*(byte_q + 2'h1) +: 8];
                  oe_d    = !is_read(op_q);
                  cs_n_d  = 1'b0;
                  cnt_d   = SU_CYC;
                  state_d = S_SETUP;
               end
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_q <= S_IDLE;
         cnt_q   <= 4'h0;
         byte_q  <= 2'h0;
         op_q    <= OP_CTRL_WR;
         wdata_q <= 24'h000000;
         rdata_q <= 24'h000000;
         rsp_q   <= 24'h000000;
         cs_n_q  <= 1'b1;
         cd_q    <= 1'b0;
         rd_n_q  <= 1'b1;
         wr_n_q  <= 1'b1;
         dout_q  <= 8'h00;
         oe_q    <= 1'b0;
         ready_q <= 1'b1;
         rsp_v_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         byte_q  <= byte_d;
         op_q    <= op_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         rsp_q   <= rsp_d;
         cs_n_q  <= cs_n_d;
         cd_q    <= cd_d;
         rd_n_q  <= rd_n_d;
         wr_n_q  <= wr_n_d;
         dout_q  <= dout_d;
         oe_q    <= oe_d;
         ready_q <= ready_d;
         rsp_v_q <= rsp_v_d;
      end
   end

   assign CMD_READY = ready_q;
   assign RSP_VALID = rsp_v_q;
   assign RSP_DATA  = rsp_q;
   assign CS_N      = cs_n_q;
   assign CD        = cd_q;
   assign RD_N      = rd_n_q;
   assign WR_N      = wr_n_q;
   assign DB_OUT    = dout_q;
   assign DB_OE     = oe_q;

   // ==========================================
   // count pins, direction changed only with A high
   qc_count_pins u_pins (
      .clk        (CLK),
      .rst_b      (RST_B),
      .step_req   (STEP_REQ),
      .step_down  (STEP_DOWN),
      .step_ready (STEP_READY),
      .pin_a      (CNT_A),
      .pin_b      (CNT_B)
   );

endmodule

/* verif/qc_host_assertions.sv */
// protocol checker on the host controller's device-side pins and command port
`timescale 1ns/1ps
module qc_host_assertions (
   // watched ports
   input wire logic       CLK,
   input wire logic       RST_B,
   input wire logic       CMD_VALID,
   input wire logic       CMD_READY,
   input wire logic       RSP_VALID,
   input wire logic       CS_N,
   input wire logic       CD,
   input wire logic       RD_N,
   input wire logic       WR_N,
   input wire logic       DB_OE,
   input wire logic [7:0] DB_OUT,
   input wire logic       CNT_A,
   input wire logic       CNT_B
);
   // ==========================================
   // bus, command-port and count-pin relations
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   chk_strobe_sel: assert property (!RD_N || !WR_N |-> !CS_N && (RD_N || WR_N))
      else $error("strobe outside select");
   chk_wr_width: assert property ($fell(WR_N) |-> (!WR_N)[*3] ##1 WR_N)
      else $error("write strobe width");
   chk_wr_setup: assert property ($fell(WR_N) |-> !$past(CS_N, 2) && DB_OE)
      else $error("write setup");
   chk_wr_hold: assert property ($rose(WR_N) |-> (!CS_N && DB_OE) ##1 (!CS_N && $stable(DB_OUT)))
      else $error("write hold");
   chk_rd_width: assert property ($fell(RD_N) |-> (!RD_N && !DB_OE)[*7] ##1 RD_N)
      else $error("read strobe width");
   chk_rsp_end: assert property (RSP_VALID |-> CMD_READY && !$past(CMD_READY))
      else $error("response not at completion");
   chk_cmd_busy: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
      else $error("command not taken");
   chk_dir_hold: assert property ($changed(CNT_B) |-> CNT_A && $past(CNT_A))
      else $error("direction changed with count input low");
   chk_count_edge: assert property ($fell(CNT_A) |=> CNT_A)
      else $error("count input low too long");
   chk_cd_steady: assert property (!CS_N && !$past(CS_N) |-> $stable(CD))
      else $error("bank select moved during access");
endmodule

bind qc_host qc_host_assertions chk (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID),
   .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .CS_N(CS_N), .CD(CD), .RD_N(RD_N), .WR_N(WR_N),
   .DB_OE(DB_OE), .DB_OUT(DB_OUT), .CNT_A(CNT_A), .CNT_B(CNT_B));

/* verif/qc_dev_model.sv */
// behavioural model of the 24-bit counter device
`timescale 1ns/1ps
module qc_dev_model (
   // bus
   input  wire logic       cs_n,
   input  wire logic       cd,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [7:0] db_out,
   input  wire logic       db_oe,
   output logic [7:0]      db_in,
   // count pins
   input  wire logic       a,
   input  wire logic       b
);
   logic [23:0] cnt, rel, snap;
   logic [7:0]  in_s, out_s, ph, last;
   logic [1:0]  ptr;
   logic        bw, cy, mt, sg, dir, halt;
   // phase decode field: 0 off, 1 x1, 2 x2, 3 x4
   wire logic       quad = ph[1:0] != 2'h0;
   // undefined top bits read as ones so the host's masking is exercised
   wire logic [7:0] stat = {3'h7, quad ? dir : 1'b1, sg, mt, cy, bw};
   wire logic [7:0] q = cd ? stat : snap[ptr*8 +: 8];
   // released bus shows the inverse of the last value, never a held copy
   assign db_in = db_oe ? db_out : (!cs_n && !rd_n) ? q : ~last;

   // ==========================================
   // counting and commands
   task automatic step(input logic dn);
      logic ev;
      if (halt) return;
      ev = dn ? (cnt == 24'h0) : (cnt == 24'hffffff);
      if (dn && cnt == 24'h0) begin
         bw = ~bw;
         sg = 1'b0;
      end
      if (!dn && cnt == 24'hffffff) begin
         cy = ~cy;
         sg = 1'b1;
      end
      cnt = dn ? cnt - 24'h1 : cnt + 24'h1;
      if (ev && out_s[2]) cnt = rel;
      if (ev && out_s[1]) halt = 1'b1;
      if (cnt == rel) mt = ~mt;
   endtask

   // one phase edge; need is the lowest resolution that counts it
   task automatic qedge(input logic up, input logic [1:0] need);
      if (in_s[3] && ph[1:0] >= need) begin
         dir = up;
         step(!up);
      end
   endtask

   task automatic mc(input logic [7:0] v);
      if (v[5]) begin
         {cnt, snap, in_s, out_s, ph, ptr, bw, cy, mt, halt} = '0;
         rel = 24'hffffff;
         sg = 1'b1;
         dir = 1'b1;
      end
      if (v[0]) ptr = 2'h0;
      if (v[1]) snap = cnt;
      if (v[2]) {cnt, bw, cy, sg} = {24'h0, 3'h1};
      if (v[3]) cnt = rel;
      if (v[4]) mt = 1'b0;
      if (v[2] || v[3]) halt = 1'b0;
   endtask

   // power-on state is not described; start as after a master reset
   initial begin
      last = 8'h0;
      mc(8'h20);
   end

   always @(posedge wr_n) begin
      if (!cs_n && !cd) begin
         rel[ptr*8 +: 8] = db_out;
         ptr = (ptr == 2'h2) ? 2'h0 : ptr + 2'h1;
      end else if (!cs_n) begin
         case (db_out[7:6])
            2'h0: mc(db_out);
            2'h1: begin
               in_s = db_out;
               if (db_out[3] && db_out[1]) step(1'b0);
               if (db_out[3] && db_out[2]) step(1'b1);
            end
            2'h2: out_s = db_out;
            default: ph = db_out;
         endcase
      end
   end

   always @(posedge rd_n) begin
      if (!cs_n) begin
         last = q;
         if (!cd) ptr = (ptr == 2'h2) ? 2'h0 : ptr + 2'h1;
      end
   end

   // quadrature overrides the plain arrangements; up means phase a leads
   always @(posedge a) begin
      if (quad) qedge(!b, 2'h1);
      else if (in_s[3]) step(in_s[0] & b);
   end
   always @(negedge a) if (quad) qedge(b, 2'h2);
   always @(posedge b) begin
      if (quad) qedge(a, 2'h3);
      else if (in_s[3] && !in_s[0]) step(1'b1);
   end
   always @(negedge b) if (quad) qedge(!a, 2'h3);
endmodule

/* verif/tb_qc_host.sv */
// self-checking bench for the host controller against the device model
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_qc_host
   import qc_host_pkg::*;
;
   logic        clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, step_req = 1'b0, step_down = 1'b0;
   logic [1:0]  cmd_op = 2'h0;
   logic [23:0] cmd_data = 24'h0;
   wire logic   cmd_ready, rsp_valid, step_ready, cs_n, cd, rd_n, wr_n, db_oe, cnt_a, cnt_b;
   wire logic [23:0] rsp_data;
   wire logic [7:0]  db_in, db_out;
   int num_errors = 0, n_compared = 0;

   qc_host dut (.CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
      .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
      .STEP_REQ(step_req), .STEP_DOWN(step_down), .STEP_READY(step_ready), .CS_N(cs_n),
      .CD(cd), .RD_N(rd_n), .WR_N(wr_n), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe),
      .CNT_A(cnt_a), .CNT_B(cnt_b));
   qc_dev_model dev (.cs_n(cs_n), .cd(cd), .rd_n(rd_n), .wr_n(wr_n), .db_out(db_out),
      .db_oe(db_oe), .db_in(db_in), .a(cnt_a), .b(cnt_b));

   initial forever #10 clk = ~clk;

   // ==========================================
   // access tasks
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmd(input logic [1:0] op, input logic [23:0] d);
      int i;
      {cmd_op, cmd_data, cmd_valid} = {op, d, 1'b1};
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) @(posedge clk) #1;
      if (i == 60) begin
         num_errors++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [1:0] op, input logic [23:0] e);
      cmd(op, 24'h0);
      `CHK("rsp_valid", 1'b1, rsp_valid)
      `CHK(op == OP_SNAP_RD ? "snapshot" : "status", e, rsp_data)
   endtask

   task automatic step(input logic dn);
      int i;
      {step_req, step_down} = {1'b1, dn};
      @(posedge clk) #1;
      step_req = 1'b0;
      for (i = 0; i < 20 && step_ready !== 1'b1; i++) @(posedge clk) #1;
      if (i == 20) begin
         num_errors++;
         end_of_test();
      end
   endtask

   // ==========================================
   // scenarios
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_b = 1'b1;
      `CHK("cs_n idle", 1'b1, cs_n)
      `CHK("bus idle", 4'b1100, {rd_n, wr_n, cd, db_oe})
      `CHK("ports idle", 3'b110, {cmd_ready, step_ready, rsp_valid})
      `CHK("count pins idle", 2'b10, {cnt_a, cnt_b})
      cmd(OP_CTRL_WR, 24'h20);
      rd(OP_STATUS_RD, 24'h18);
      cmd(OP_CTRL_WR, 24'h49);
      cmd(OP_CTRL_WR, 24'h80);
      cmd(OP_CTRL_WR, 24'hc0);
      cmd(OP_CTRL_WR, 24'h01);
      cmd(OP_RELOAD_WR, 24'h123456);
      cmd(OP_CTRL_WR, 24'h08);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'h123456);
      repeat (3) step(1'b0);
      repeat (2) step(1'b1);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'h123457);
      cmd(OP_CTRL_WR, 24'h4b);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'h123458);
      cmd(OP_CTRL_WR, 24'h04);
      step(1'b1);
      rd(OP_STATUS_RD, 24'h11);
      step(1'b0);
      rd(OP_STATUS_RD, 24'h1b);
      cmd(OP_CTRL_WR, 24'h01);
      cmd(OP_RELOAD_WR, 24'h000002);
      repeat (2) step(1'b0);
      rd(OP_STATUS_RD, 24'h1f);
      cmd(OP_CTRL_WR, 24'h10);
      rd(OP_STATUS_RD, 24'h1b);
      cmd(OP_CTRL_WR, 24'hc3);
      step(1'b1);
      rd(OP_STATUS_RD, 24'h0b);
      cmd(OP_CTRL_WR, 24'hc0);
      rd(OP_STATUS_RD, 24'h1b);
      cmd(OP_CTRL_WR, 24'hc1);
      step(1'b0);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'h000004);
      cmd(OP_CTRL_WR, 24'hc0);
      cmd(OP_CTRL_WR, 24'h84);
      cmd(OP_CTRL_WR, 24'h04);
      step(1'b1);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'h000002);
      cmd(OP_CTRL_WR, 24'h82);
      cmd(OP_CTRL_WR, 24'h04);
      repeat (2) step(1'b1);
      cmd(OP_CTRL_WR, 24'h03);
      rd(OP_SNAP_RD, 24'hffffff);
      cmd(OP_CTRL_WR, 24'h20);
      rd(OP_STATUS_RD, 24'h18);
      rd(OP_SNAP_RD, 24'h000000);
      end_of_test();
   end
endmodule
